// >>> pulse_signal_reset_regs.sv
`timescale 1ns/1ps
`include "pulse_signal_reset_defines.svh"
module pulse_signal_reset_regs
    import pulse_signal_reset_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [3:0] host_lines,
    input wire logic pulse_start,
    output logic pulse_out,
    output logic soft_reset_active,
    output logic [7:0] firmware_revision_register,
    output logic irq
);

    // ****************************************
    // Bus address phase capture
    // ****************************************
    logic wr_pend_q, wr_pend_d;
    logic rd_pend_q, rd_pend_d;
    logic [7:0] idx_q, idx_d;
    logic addr_ok;

    function automatic logic is_sel(input logic [7:0] idx, input logic [7:0] want);
        is_sel = (idx == want);
    endfunction

    // Only whole-word transfers reach the registers; narrower sizes are ignored
    assign addr_ok = hsel && hready && htrans[1] && (hsize == 3'b010) && (haddr[1:0] == 2'b00)
        && (haddr[31:10] == 22'h000000);

    always_comb
    begin
        wr_pend_d = addr_ok && hwrite;
        rd_pend_d = addr_ok && !hwrite;
        idx_d = addr_ok ? haddr[9:2] : idx_q;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            idx_q <= 8'h00;
        end
        else
        begin
            wr_pend_q <= wr_pend_d;
            rd_pend_q <= rd_pend_d;
            idx_q <= idx_d;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ****************************************
    // Line synchronisers
    // ****************************************
    // Three stages; a change counts once stages two and three agree
    logic [3:0] s1_q, s2_q, s3_q, stable_q, stable_d;

    always_comb
    begin
        stable_d = (s2_q == s3_q) ? s3_q : stable_q;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s1_q <= 4'hf;
            s2_q <= 4'hf;
            s3_q <= 4'hf;
            stable_q <= 4'hf;
        end
        else
        begin
            s1_q <= host_lines;
            s2_q <= s1_q;
            s3_q <= s2_q;
            stable_q <= stable_d;
        end
    end

    // ****************************************
    // Register file
    // ****************************************
    logic [7:0] spw_q, spw_d;
    logic [3:0] fede_q, fede_d;
    logic [3:0] lcs_q, lcs_d;
    logic [7:0] mode_q, mode_d;
    logic [2:0] ists_q, ists_d;
    logic [2:0] imask_q, imask_d;
    logic [3:0] fall;
    logic manual;
    logic wr_spw, wr_fede, wr_lcs, wr_mode, wr_imask, wr_rst, rd_ists;
    logic reset_cmd;
    logic pulse_done;
    logic reset_done;
    logic chan_ok;

    assign manual = mode_q[`MODE_MANUAL_BIT];
    assign chan_ok = (mode_q[`MODE_CHAN_LSB +: 2] == 2'd2) || (mode_q[`MODE_CHAN_LSB +: 2] == 2'd3);
    assign wr_spw = wr_pend_q && is_sel(idx_q, `IDX_SHORT_PULSE_WIDTH);
    assign wr_fede = wr_pend_q && is_sel(idx_q, `IDX_FALLING_EDGE_DETECT_ENABLE);
    assign wr_lcs = wr_pend_q && is_sel(idx_q, `IDX_LINE_CHANGE_STATUS);
    assign wr_mode = wr_pend_q && is_sel(idx_q, `IDX_MODE_CONTROL);
    assign wr_imask = wr_pend_q && is_sel(idx_q, `IDX_IRQ_MASK);
    assign wr_rst = wr_pend_q && is_sel(idx_q, `IDX_SOFTWARE_RESET_COMMAND) && chan_ok;
    assign rd_ists = rd_pend_q && is_sel(idx_q, `IDX_IRQ_STATUS);
    assign reset_cmd = wr_rst && (hwdata[7:0] == `RESET_CMD_VALUE);
    assign fall = stable_q & ~stable_d & fede_q & {4{manual}};

    always_comb
    begin
        spw_d = wr_spw ? hwdata[7:0] : spw_q;
        fede_d = wr_fede ? hwdata[`LINE_MSB:0] : fede_q;
        mode_d = wr_mode ? hwdata[7:0] : mode_q;
        imask_d = wr_imask ? hwdata[2:0] : imask_q;
        // Set wins over the write-clear so no edge is lost
        lcs_d = (wr_lcs ? 4'h0 : lcs_q) | fall;
        // Clear only what the read returned, so an event between address and data phase is kept
        ists_d = rd_ists ? (ists_q & ~rdata_q[2:0]) : ists_q;
        ists_d[`IRQ_LINE_CHANGE_BIT] = ists_d[`IRQ_LINE_CHANGE_BIT] | ((|fall) & mode_q[`MODE_SIGNAL_CHANGE_IRQ_ENABLE_BIT]);
        ists_d[`IRQ_PULSE_DONE_BIT] = ists_d[`IRQ_PULSE_DONE_BIT] | pulse_done;
        ists_d[`IRQ_RESET_DONE_BIT] = ists_d[`IRQ_RESET_DONE_BIT] | reset_done;
    end

    // ****************************************
    // Soft reset sequencer
    // ****************************************
    logic [4:0] rst_cnt_q, rst_cnt_d;
    logic [7:0] fwrev_q, fwrev_d;

    always_comb
    begin
        rst_cnt_d = rst_cnt_q;
        if (reset_cmd)
            rst_cnt_d = 5'(`SOFT_RESET_CYCLES);
        else if (rst_cnt_q != 5'd0)
            rst_cnt_d = rst_cnt_q - 5'd1;
        fwrev_d = (reset_cmd || rst_cnt_q > 5'd1) ? 8'h00 : `FW_REVISION_VALUE;
    end

    assign reset_done = (rst_cnt_q == 5'd1);
    assign soft_reset_active = (rst_cnt_q != 5'd0);

    // A soft reset returns every register except the IRQ status to its reset value
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rst_cnt_q <= 5'd0;
            fwrev_q <= 8'h00;
            ists_q <= 3'b000;
        end
        else
        begin
            rst_cnt_q <= rst_cnt_d;
            fwrev_q <= fwrev_d;
            ists_q <= ists_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            spw_q <= `REG_RESET_VALUE;
            fede_q <= 4'h0;
            lcs_q <= 4'h0;
            mode_q <= `REG_RESET_VALUE;
            imask_q <= 3'b000;
        end
        else if (soft_reset_active)
        begin
            spw_q <= `REG_RESET_VALUE;
            fede_q <= 4'h0;
            lcs_q <= 4'h0;
            mode_q <= `REG_RESET_VALUE;
            imask_q <= 3'b000;
        end
        else
        begin
            spw_q <= spw_d;
            fede_q <= fede_d;
            lcs_q <= lcs_d;
            mode_q <= mode_d;
            imask_q <= imask_d;
        end
    end

    assign firmware_revision_register = fwrev_q;
    assign irq = |(ists_q & imask_q);

    // ****************************************
    // Pulse timer
    // ****************************************
    pulse_state_e pst_q, pst_d;
    logic [8:0] pcnt_q, pcnt_d;
    logic pout_q, pout_d;

    always_comb
    begin
        pst_d = pst_q;
        pcnt_d = pcnt_q;
        pout_d = pout_q;
        pulse_done = 1'b0;
        case (pst_q)
            PULSE_IDLE:
            begin
                if (pulse_start && !soft_reset_active)
                begin
                    pst_d = PULSE_RUN;
                    pout_d = 1'b1;
                    if (mode_q[`MODE_COMPAT_BIT])
                        pcnt_d = {1'b0, spw_q};
                    else
                        pcnt_d = {1'b0, spw_q} + 9'd2;
                end
            end
            PULSE_RUN:
            begin
                if (pcnt_q <= 9'd1)
                begin
                    pst_d = PULSE_IDLE;
                    pout_d = 1'b0;
                    pulse_done = 1'b1;
                end
                else
                    pcnt_d = pcnt_q - 9'd1;
            end
            default:
            begin
                pst_d = PULSE_IDLE;
                pout_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pst_q <= PULSE_IDLE;
            pcnt_q <= 9'd0;
            pout_q <= 1'b0;
        end
        else
        begin
            pst_q <= pst_d;
            pcnt_q <= pcnt_d;
            pout_q <= pout_d;
        end
    end

    assign pulse_out = pout_q;

    // ****************************************
    // Read data
    // ****************************************
    logic [31:0] rdata_q, rdata_d;

    always_comb
    begin
        rdata_d = 32'h00000000;
        if (rd_pend_d)
        begin
            case (haddr[9:2])
                `IDX_SHORT_PULSE_WIDTH: rdata_d[7:0] = spw_q;
                `IDX_FALLING_EDGE_DETECT_ENABLE: rdata_d[3:0] = fede_q;
                `IDX_LINE_CHANGE_STATUS: rdata_d[3:0] = lcs_q;
                `IDX_MODE_CONTROL: rdata_d[7:0] = mode_q;
                `IDX_IRQ_STATUS: rdata_d[2:0] = ists_q;
                `IDX_IRQ_MASK: rdata_d[2:0] = imask_q;
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata_q <= 32'h00000000;
        else
            rdata_q <= rdata_d;
    end

    assign hrdata = rdata_q;

endmodule // pulse_signal_reset_regs

// >>> pulse_signal_reset_defines.svh
`ifndef PULSE_SIGNAL_RESET_DEFINES_SVH
`define PULSE_SIGNAL_RESET_DEFINES_SVH

// ****************************************
// Register offsets (printed offsets are indices, byte address = 4 * index)
// ****************************************
`define IDX_SOFTWARE_RESET_COMMAND 8'h05
`define IDX_SHORT_PULSE_WIDTH 8'h26
`define IDX_FALLING_EDGE_DETECT_ENABLE 8'h2c
`define IDX_LINE_CHANGE_STATUS 8'h2f
`define IDX_MODE_CONTROL 8'h30
`define IDX_IRQ_STATUS 8'h31
`define IDX_IRQ_MASK 8'h32

// ****************************************
// Field positions and values
// ****************************************
`define RESET_CMD_VALUE 8'h81
`define REG_RESET_VALUE 8'h00
`define LINE_MSB 3
`define MODE_MANUAL_BIT 0
`define MODE_COMPAT_BIT 1
`define MODE_SIGNAL_CHANGE_IRQ_ENABLE_BIT 2
`define MODE_CHAN_LSB 4
`define IRQ_LINE_CHANGE_BIT 0
`define IRQ_PULSE_DONE_BIT 1
`define IRQ_RESET_DONE_BIT 2

// ****************************************
// Timing count and firmware revision value
// ****************************************
`define SOFT_RESET_CYCLES 16
`define FW_REVISION_VALUE 8'h5a

`endif

// >>> pulse_signal_reset_pkg.sv
package pulse_signal_reset_pkg;
    typedef enum logic [1:0] {PULSE_IDLE, PULSE_RUN} pulse_state_e;
    typedef logic [7:0] byte_t;
endpackage

// >>> host_port_model.sv
`timescale 1ns/1ps
// ****************
// Host line model
// ****************
module host_port_model (
    input wire logic hclk,
    output logic [3:0] host_lines
);
    // Lines are pulled up by the host side, so they idle high
    initial host_lines = 4'hf;
    task automatic drop(input logic [3:0] m);
        host_lines <= ~m;
        repeat (6) @(posedge hclk);
        host_lines <= 4'hf;
    endtask
endmodule // host_port_model

// >>> pulse_signal_reset_regs_properties.sv
`timescale 1ns/1ps
// ****************
// Port checker
// ****************
module pulse_signal_reset_regs_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic pulse_start,
    input wire logic pulse_out,
    input wire logic soft_reset_active,
    input wire logic [7:0] firmware_revision_register,
    input wire logic irq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd_q;
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            rd_q <= 1'b0;
        else
            rd_q <= hsel & hready & htrans[1] & !hwrite;
    chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
    chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
    chk_idle_rdata: assert property (!rd_q |-> hrdata == 32'h0) else $error("hrdata outside read");
    chk_upper_zero: assert property (rd_q |-> hrdata[31:8] == 24'h0) else $error("upper bits set");
    chk_pulse_launch: assert property (pulse_start && !pulse_out && !soft_reset_active |=> pulse_out)
        else $error("pulse not launched");
    chk_reset_len: assert property ($rose(soft_reset_active) |-> soft_reset_active[*8] ##1 soft_reset_active[*8]
        ##1 !soft_reset_active) else $error("soft reset length");
    chk_fw_hidden: assert property (soft_reset_active |-> firmware_revision_register == 8'h00)
        else $error("revision valid in reset");
    chk_fw_valid: assert property ($fell(soft_reset_active) |-> ##[1:4] firmware_revision_register == 8'h5a)
        else $error("revision not valid");
    cover property ($rose(soft_reset_active));
    cover property ($rose(irq));
    cover property ($rose(pulse_out));
endmodule // pulse_signal_reset_regs_props
bind pulse_signal_reset_regs pulse_signal_reset_regs_props chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pulse_start(pulse_start), .pulse_out(pulse_out), .soft_reset_active(soft_reset_active),
    .firmware_revision_register(firmware_revision_register), .irq(irq));

// >>> pulse_signal_reset_regs_bench.sv
`timescale 1ns/1ps
`include "pulse_signal_reset_defines.svh"
// ****************
// Register bench
// ****************
module pulse_signal_reset_regs_bench import pulse_signal_reset_pkg::*;;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, pulse_start = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hrdata;
    logic hreadyout, hresp, pulse_out, sra, irq;
    logic [7:0] fw;
    logic [3:0] host_lines;
    int bad_count = 0, n_compared = 0;
    // Reset table, with one unmapped index at the end
    logic [7:0] dut_idx [5] = '{8'h05, 8'h26, 8'h2c, 8'h2f, 8'h3f};
    always #10 hclk = ~hclk;
    host_port_model line_model (.hclk(hclk), .host_lines(host_lines));
    pulse_signal_reset_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .host_lines(host_lines), .pulse_start(pulse_start),
        .pulse_out(pulse_out), .soft_reset_active(sra), .firmware_revision_register(fw), .irq(irq));
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] e, input string m);
        n_compared++;
        if (got !== e)
        begin
            bad_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, e);
        end
    endtask
    // Hready is polled under a bound so a stuck slave ends the run
    task automatic wait_rdy;
        for (int k = 0; k < 50; k++)
        begin
            @(posedge hclk);
            if (hreadyout === 1'b1)
                return;
        end
        bad_count++;
        end_sim;
    endtask
    task automatic bus(input logic w, input logic [7:0] i, input byte_t d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, i, 2'h0};
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy;
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] i, input byte_t d);
        logic [31:0] r;
        bus(1'b1, i, d, r);
    endtask
    task automatic rd(input logic [7:0] i, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, i, 8'h00, r);
        chk(r, e, "register read");
    endtask
    task automatic irq_is(input logic e);
        @(posedge hclk);
        chk({31'h0, irq}, {31'h0, e}, "irq level");
    endtask
    task automatic pulse(input int e);
        int n;
        pulse_start <= 1'b1;
        @(posedge hclk);
        pulse_start <= 1'b0;
        n = 0;
        repeat (300)
        begin
            @(posedge hclk);
            if (pulse_out === 1'b1)
                n++;
            else if (n > 0)
                break;
        end
        chk(32'(n), 32'(e), "pulse length");
    endtask
    task automatic fall(input logic [3:0] m);
        line_model.drop(m);
        repeat (6) @(posedge hclk);
    endtask
    task automatic wait_hi(input int s);
        for (int k = 0; k < 60; k++)
        begin
            @(posedge hclk);
            if ((s == 0 && sra === 1'b1) || (s == 1 && fw === 8'h5a))
                return;
        end
        bad_count++;
        end_sim;
    endtask
    initial
    begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (dut_idx[j]) rd(dut_idx[j], 32'h0);
        wr(`IDX_SHORT_PULSE_WIDTH, 8'ha5);
        rd(`IDX_SHORT_PULSE_WIDTH, 32'ha5);
        wr(`IDX_FALLING_EDGE_DETECT_ENABLE, 8'hff);
        rd(`IDX_FALLING_EDGE_DETECT_ENABLE, 32'h0f);
        $display("registers done");
        wr(`IDX_MODE_CONTROL, 8'h04);
        wr(`IDX_IRQ_MASK, 8'h01);
        fall(4'h1);
        rd(`IDX_LINE_CHANGE_STATUS, 32'h0);
        wr(`IDX_MODE_CONTROL, 8'h05);
        wr(`IDX_FALLING_EDGE_DETECT_ENABLE, 8'h05);
        fall(4'h6);
        rd(`IDX_LINE_CHANGE_STATUS, 32'h04);
        rd(`IDX_LINE_CHANGE_STATUS, 32'h04);
        irq_is(1'b1);
        rd(`IDX_IRQ_STATUS, 32'h01);
        irq_is(1'b0);
        wr(`IDX_LINE_CHANGE_STATUS, 8'h00);
        rd(`IDX_LINE_CHANGE_STATUS, 32'h0);
        wr(`IDX_IRQ_MASK, 8'h00);
        fall(4'h1);
        irq_is(1'b0);
        wr(`IDX_IRQ_MASK, 8'h01);
        irq_is(1'b1);
        rd(`IDX_IRQ_STATUS, 32'h01);
        $display("line change done");
        wr(`IDX_MODE_CONTROL, 8'h00);
        wr(`IDX_SHORT_PULSE_WIDTH, 8'd23);
        pulse(25);
        wr(`IDX_MODE_CONTROL, 8'h02);
        wr(`IDX_SHORT_PULSE_WIDTH, 8'd7);
        pulse(7);
        $display("pulse done");
        wr(`IDX_MODE_CONTROL, 8'h00);
        wr(`IDX_SOFTWARE_RESET_COMMAND, `RESET_CMD_VALUE);
        repeat (4) @(posedge hclk);
        chk({31'h0, sra}, 32'h0, "reset on wrong channel");
        wr(`IDX_MODE_CONTROL, 8'h20);
        wr(`IDX_SOFTWARE_RESET_COMMAND, 8'h82);
        repeat (4) @(posedge hclk);
        chk({31'h0, sra}, 32'h0, "reset on wrong value");
        wr(`IDX_MODE_CONTROL, 8'h30);
        wr(`IDX_SOFTWARE_RESET_COMMAND, `RESET_CMD_VALUE);
        wait_hi(0);
        wait_hi(1);
        rd(`IDX_SHORT_PULSE_WIDTH, 32'h0);
        rd(`IDX_MODE_CONTROL, 32'h0);
        rd(`IDX_IRQ_STATUS, 32'h06);
        $display("soft reset done");
        end_sim;
    end
endmodule // pulse_signal_reset_regs_bench
